/* File: src/pin_share_cfg.svh */
// Offsets, field positions, reset values and counts for the pin-sharing block
`ifndef PIN_SHARE_CFG_SVH
`define PIN_SHARE_CFG_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PS_REG_STATUS 8'h00
`define PS_REG_MGMT 8'h04
`define PS_REG_CELL 8'h08
`define PS_REG_RXBYTE 8'h0C
// ****************************************************************
// Field positions
// ****************************************************************
`define PS_ST_VALID 0
`define PS_ST_CELL 1
`define PS_ST_MODE_LO 2
`define PS_ST_ADDR4 4
`define PS_ST_ADDR3 5
`define PS_ST_MDIO_IN 6
`define PS_MG_CLK 0
`define PS_MG_DOUT 1
`define PS_MG_OE 2
`define PS_CL_AVAIL 0
`define PS_RX_MARKER 8
`define PS_RX_FRESH 9
// ****************************************************************
// Reset values, counts and responses
// ****************************************************************
`define PS_MGMT_RST 3'h0
`define PS_CELL_RST 1'h0
`define PS_CFG_SETTLE 2'h3
`define PS_RESP_OKAY 2'h0
`define PS_RESP_SLVERR 2'h2
`endif

/* File: src/pin_share_pkg.sv */
// Types shared by the pin-sharing block
package pin_share_pkg;
   typedef enum logic [1:0] {MODE_MII, MODE_RMII, MODE_GMII, MODE_RGMII} mac_mode_e;
   typedef enum logic {CFG_WAIT, CFG_HOLD} cfg_state_e;
endpackage : pin_share_pkg

/* File: src/sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;
   // First stage is read only by the second
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_q <= '0;
         q_o <= '0;
      end
      else
      begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : sync2

/* File: src/axil_slave.sv */
// AXI4-Lite slave front end turning bus beats into one-cycle register strobes
`timescale 1ns/1ps
`include "pin_share_cfg.svh"
module axil_slave #(
   parameter int AW = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [AW-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic wr_o,
   output logic [AW-1:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic [3:0] wr_strb_o,
   input wire logic wr_err_i,
   output logic rd_o,
   output logic [AW-1:0] rd_addr_o,
   input wire logic [31:0] rd_data_i,
   input wire logic rd_err_i
);
   logic aw_full_q;
   logic w_full_q;
   logic [AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   // Address and data may arrive in either order; hold each until both are in
   assign s_axi_awready_o = !aw_full_q && !s_axi_bvalid_o;
   assign s_axi_wready_o = !w_full_q && !s_axi_bvalid_o;
   assign s_axi_arready_o = !s_axi_rvalid_o;
   assign wr_o = aw_full_q && w_full_q && !s_axi_bvalid_o;
   assign wr_addr_o = awaddr_q;
   assign wr_data_o = wdata_q;
   assign wr_strb_o = wstrb_q;
   assign rd_o = s_axi_arvalid_i && s_axi_arready_o;
   assign rd_addr_o = s_axi_araddr_i;
   // Write channel capture and response
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `PS_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
         end
         if (wr_o)
         begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_err_i ? `PS_RESP_SLVERR : `PS_RESP_OKAY;
         end
         else if (s_axi_bready_i)
         begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end
   // Read channel: data registered on the address beat
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= `PS_RESP_OKAY;
      end
      else if (rd_o)
      begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_data_i;
         s_axi_rresp_o <= rd_err_i ? `PS_RESP_SLVERR : `PS_RESP_OKAY;
      end
      else if (s_axi_rready_i)
      begin
         s_axi_rvalid_o <= 1'b0;
      end
   end
   // A pending response holds until the master takes it
   property p_bvalid_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
endmodule : axil_slave

/* File: src/cell_port_mac_pin_sharing.sv */
// Pin sharing between the cell slave port and the MAC with its management port
// Function
// - Cell mode: pin A is address bit 4 input; else drives management clock.
// - Cell mode: pin B is address bit 3 input; else bidirectional management data.
// - RGMII uses the dedicated alternate management clock and data pins.
// - With cell port off, two select bits choose one of four MAC modes.
// - Receive clock serves the cell receiver, else MAC receive clock for MII/GMII.
// - Cell mode: device drives receive cell-available status on the shared pin.
// - Cell port off: status pin is input, carrier sense or RMII CRS/valid.
// - Marker pin is start-of-cell in cell mode, else MAC receive error.
// - After enable asserts, bus and marker are sampled next receive clock on.
// - Cell port off: enable pin is MAC receive valid in MII or GMII.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "pin_share_cfg.svh"
module cell_port_mac_pin_sharing (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cell_rx_clk_i,
   input wire logic cell_port_enable_i,
   input wire logic [1:0] mac_if_select_pins_i,
   input wire logic pin_a_i,
   output logic pin_a_o,
   output logic pin_a_oe_n_o,
   input wire logic pin_b_i,
   output logic pin_b_o,
   output logic pin_b_oe_n_o,
   output logic mgmt_serial_clk_alt_o,
   output logic mgmt_serial_clk_alt_oe_n_o,
   input wire logic mgmt_serial_data_alt_i,
   output logic mgmt_serial_data_alt_o,
   output logic mgmt_serial_data_alt_oe_n_o,
   input wire logic pin_clav_i,
   output logic pin_clav_o,
   output logic pin_clav_oe_n_o,
   input wire logic pin_marker_i,
   input wire logic pin_rx_enable_i,
   input wire logic [7:0] cell_rx_bus_i,
   output logic mac_rx_clk_o,
   output logic mac_carrier_sense_o,
   output logic reduced_crs_valid_o,
   output logic mac_rx_error_o,
   output logic reduced_rx_error_o,
   output logic mac_rx_valid_o,
   output logic tx_cell_addr_bit4_o,
   output logic tx_cell_addr_bit3_o,
   output logic cell_port_enable_o,
   output pin_share_pkg::mac_mode_e mac_mode_o,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);
   import pin_share_pkg::*;

   // ****************************************************************
   // Pin synchronisers and strap capture
   // ****************************************************************
   logic [8:0] pins_s;
   logic a_s, b_s, alt_s, clav_s, marker_s, enable_s, strap_cell_s;
   logic [1:0] strap_sel_s;
   cfg_state_e cfg_q;
   logic [1:0] settle_q;
   logic cell_q;
   mac_mode_e mode_q;

   sync2 #(.WIDTH(9)) u_pin_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({pin_a_i, pin_b_i, mgmt_serial_data_alt_i, pin_clav_i, pin_marker_i,
            pin_rx_enable_i, cell_port_enable_i, mac_if_select_pins_i}),
      .q_o(pins_s)
   );
   assign {a_s, b_s, alt_s, clav_s, marker_s, enable_s, strap_cell_s, strap_sel_s} = pins_s;

   // Wait for the synchroniser to fill, then freeze the straps until next reset
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cfg_q <= CFG_WAIT;
         settle_q <= 2'h0;
         cell_q <= 1'b0;
         mode_q <= MODE_MII;
      end
      else
      begin
         case (cfg_q)
            CFG_WAIT:
            begin
               settle_q <= settle_q + 2'h1;
               if (settle_q == `PS_CFG_SETTLE)
               begin
                  cfg_q <= CFG_HOLD;
                  cell_q <= strap_cell_s;
                  mode_q <= mac_mode_e'(strap_sel_s);
               end
            end
            default:
            begin
               cfg_q <= CFG_HOLD;
            end
         endcase
      end
   end

   // ****************************************************************
   // Mode decode
   // ****************************************************************
   // Until the straps are frozen every shared pin stays an input
   wire cfg_valid = (cfg_q == CFG_HOLD);
   wire cell_on = cfg_valid && cell_q;
   wire mac_on = cfg_valid && !cell_q;
   wire is_mii = mac_on && (mode_q == MODE_MII);
   wire is_rmii = mac_on && (mode_q == MODE_RMII);
   wire is_gmii = mac_on && (mode_q == MODE_GMII);
   wire is_rgmii = mac_on && (mode_q == MODE_RGMII);
   wire mgmt_shared = is_mii || is_rmii || is_gmii;
   assign cell_port_enable_o = cell_q;
   assign mac_mode_o = mode_q;

   // ****************************************************************
   // Register strobes and software state
   // ****************************************************************
   logic wr, rd;
   logic [7:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [2:0] mgmt_q;
   logic avail_q;
   logic [7:0] rx_byte_q;
   logic rx_marker_q;
   logic fresh_q;
   logic new_byte;

   wire hit_status = (rd_addr == `PS_REG_STATUS);
   wire hit_mgmt_r = (rd_addr == `PS_REG_MGMT);
   wire hit_cell_r = (rd_addr == `PS_REG_CELL);
   wire hit_rx_r = (rd_addr == `PS_REG_RXBYTE);
   wire hit_mgmt_w = (wr_addr == `PS_REG_MGMT);
   wire hit_cell_w = (wr_addr == `PS_REG_CELL);
   wire wr_known = (wr_addr == `PS_REG_STATUS) || (wr_addr == `PS_REG_RXBYTE) ||
                   hit_mgmt_w || hit_cell_w;
   wire rd_err = !(hit_status || hit_mgmt_r || hit_cell_r || hit_rx_r);
   wire mdio_in = is_rgmii ? alt_s : b_s;

   // Read mux; status shows the frozen straps and the sampled pins
   wire [31:0] status_word = {25'h0, mdio_in, b_s && cell_on, a_s && cell_on,
                              mode_q, cell_q, cfg_valid};
   assign rd_data = hit_status ? status_word :
                    hit_mgmt_r ? {29'h0, mgmt_q} :
                    hit_cell_r ? {31'h0, avail_q} :
                    hit_rx_r ? {22'h0, fresh_q, rx_marker_q, rx_byte_q} :
                    32'h0000_0000;

   axil_slave #(.AW(8)) u_bus (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .s_axi_awaddr_i(s_axi_awaddr_i),
      .s_axi_awvalid_i(s_axi_awvalid_i),
      .s_axi_awready_o(s_axi_awready_o),
      .s_axi_wdata_i(s_axi_wdata_i),
      .s_axi_wstrb_i(s_axi_wstrb_i),
      .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o),
      .s_axi_bresp_o(s_axi_bresp_o),
      .s_axi_bvalid_o(s_axi_bvalid_o),
      .s_axi_bready_i(s_axi_bready_i),
      .s_axi_araddr_i(s_axi_araddr_i),
      .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o),
      .s_axi_rdata_o(s_axi_rdata_o),
      .s_axi_rresp_o(s_axi_rresp_o),
      .s_axi_rvalid_o(s_axi_rvalid_o),
      .s_axi_rready_i(s_axi_rready_i),
      .wr_o(wr),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_err_i(!wr_known),
      .rd_o(rd),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_err_i(rd_err)
   );

   // Control registers; only byte lane 0 carries fields
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mgmt_q <= `PS_MGMT_RST;
         avail_q <= `PS_CELL_RST;
      end
      else if (wr && wr_strb[0])
      begin
         if (hit_mgmt_w)
            mgmt_q <= wr_data[2:0];
         else if (hit_cell_w)
            avail_q <= wr_data[`PS_CL_AVAIL];
      end
   end

   // ****************************************************************
   // Management pins
   // ****************************************************************
   // Shared pair drives only in MII, RMII or GMII; in cell mode both are inputs
   assign pin_a_o = mgmt_q[`PS_MG_CLK];
   assign pin_a_oe_n_o = !mgmt_shared;
   assign pin_b_o = mgmt_q[`PS_MG_DOUT];
   assign pin_b_oe_n_o = !(mgmt_shared && mgmt_q[`PS_MG_OE]);
   assign tx_cell_addr_bit4_o = cell_on && a_s;
   assign tx_cell_addr_bit3_o = cell_on && b_s;
   // Dedicated pair carries management only in RGMII
   assign mgmt_serial_clk_alt_o = mgmt_q[`PS_MG_CLK];
   assign mgmt_serial_clk_alt_oe_n_o = !is_rgmii;
   assign mgmt_serial_data_alt_o = mgmt_q[`PS_MG_DOUT];
   assign mgmt_serial_data_alt_oe_n_o = !(is_rgmii && mgmt_q[`PS_MG_OE]);

   // ****************************************************************
   // MAC receive side signals
   // ****************************************************************
   // Registered selections; zero whenever the pin belongs to the cell port
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mac_carrier_sense_o <= 1'b0;
         reduced_crs_valid_o <= 1'b0;
         mac_rx_error_o <= 1'b0;
         reduced_rx_error_o <= 1'b0;
         mac_rx_valid_o <= 1'b0;
      end
      else
      begin
         mac_carrier_sense_o <= (is_mii || is_gmii) && clav_s;
         reduced_crs_valid_o <= is_rmii && clav_s;
         mac_rx_error_o <= (is_mii || is_gmii) && marker_s;
         reduced_rx_error_o <= is_rmii && marker_s;
         mac_rx_valid_o <= (is_mii || is_gmii) && enable_s;
      end
   end

   // ****************************************************************
   // Receive clock domain
   // ****************************************************************
   logic [2:0] link_s;
   logic cell_link, mac_clk_en_link, avail_link;
   logic enb_q;
   logic [7:0] cap_byte_q;
   logic cap_marker_q;
   logic cap_tgl_q;
   logic tgl_s, tgl_prev_q;

   sync2 #(.WIDTH(3)) u_link_sync (
      .clk_i(cell_rx_clk_i),
      .rst_n_i(rst_n_i),
      .d_i({cell_on, is_mii || is_gmii, avail_q}),
      .q_o(link_s)
   );
   assign {cell_link, mac_clk_en_link, avail_link} = link_s;

   // Static after capture, so gating the clock only switches once per reset
   assign mac_rx_clk_o = cell_rx_clk_i && mac_clk_en_link;

   // Status pin driven from the receive clock so the master samples it cleanly
   always_ff @(posedge cell_rx_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         pin_clav_o <= 1'b0;
      else
         pin_clav_o <= avail_link && cell_link;
   end
   assign pin_clav_oe_n_o = !cell_on;

   // Enable seen on one edge lets the bus be taken on the next edge
   always_ff @(posedge cell_rx_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         enb_q <= 1'b0;
         cap_byte_q <= 8'h00;
         cap_marker_q <= 1'b0;
         cap_tgl_q <= 1'b0;
      end
      else
      begin
         enb_q <= pin_rx_enable_i && cell_link;
         if (enb_q && pin_rx_enable_i)
         begin
            cap_byte_q <= cell_rx_bus_i;
            cap_marker_q <= pin_marker_i;
            cap_tgl_q <= !cap_tgl_q;
         end
      end
   end

   // ****************************************************************
   // Captured byte into the register clock domain
   // ****************************************************************
   // Limitation: the byte must stay put for the toggle crossing, so one byte per
   // receive clock is kept only while that clock is several times slower
   sync2 #(.WIDTH(1)) u_tgl_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(cap_tgl_q),
      .q_o(tgl_s)
   );
   assign new_byte = tgl_s ^ tgl_prev_q;

   // Fresh flag: a new byte in the cycle of the clearing read wins
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tgl_prev_q <= 1'b0;
         rx_byte_q <= 8'h00;
         rx_marker_q <= 1'b0;
         fresh_q <= 1'b0;
      end
      else
      begin
         tgl_prev_q <= tgl_s;
         if (new_byte)
         begin
            rx_byte_q <= cap_byte_q;
            rx_marker_q <= cap_marker_q;
            fresh_q <= 1'b1;
         end
         else if (rd && hit_rx_r)
            fresh_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_addr4_in;
      @(posedge clk_i) disable iff (!rst_n_i)
      cell_on |-> pin_a_oe_n_o && (tx_cell_addr_bit4_o == a_s);
   endproperty
   a_addr4_in: assert property (p_addr4_in) else $error("pin A driven in cell mode");
   property p_addr3_in;
      @(posedge clk_i) disable iff (!rst_n_i)
      cell_on |-> pin_b_oe_n_o && (tx_cell_addr_bit3_o == b_s);
   endproperty
   a_addr3_in: assert property (p_addr3_in) else $error("pin B driven in cell mode");
   property p_alt_pair;
      @(posedge clk_i) disable iff (!rst_n_i)
      !mgmt_serial_clk_alt_oe_n_o |-> is_rgmii && pin_a_oe_n_o && pin_b_oe_n_o;
   endproperty
   a_alt_pair: assert property (p_alt_pair) else $error("alternate pair misused");
   property p_one_mode;
      @(posedge clk_i) disable iff (!rst_n_i)
      mac_on |-> $onehot({is_mii, is_rmii, is_gmii, is_rgmii});
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("MAC mode not unique");
   property p_clav_dir;
      @(posedge clk_i) disable iff (!rst_n_i)
      cfg_valid |-> (pin_clav_oe_n_o == !cell_q);
   endproperty
   a_clav_dir: assert property (p_clav_dir) else $error("status pin direction wrong");
   property p_crs_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      cell_on ##1 cell_on |-> !mac_carrier_sense_o && !reduced_crs_valid_o;
   endproperty
   a_crs_off: assert property (p_crs_off) else $error("carrier sense in cell mode");
   property p_err_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cell_on || is_rgmii) ##1 cfg_valid |-> !mac_rx_error_o && !mac_rx_valid_o;
   endproperty
   a_err_off: assert property (p_err_off) else $error("MAC input leaked");
   property p_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      cfg_valid |=> cfg_valid && $stable(cell_q) && $stable(mode_q);
   endproperty
   a_hold: assert property (p_hold) else $error("straps changed after capture");
   property p_sample;
      @(posedge cell_rx_clk_i) disable iff (!rst_n_i)
      enb_q && pin_rx_enable_i |=> cap_byte_q == $past(cell_rx_bus_i);
   endproperty
   a_sample: assert property (p_sample) else $error("receive byte not taken");
endmodule : cell_port_mac_pin_sharing

/* File: verif/link_partner.sv */
// Far-side model: cell master or PHY on the shared receive pins
`timescale 1ns/1ps
module link_partner (
   output logic cell_rx_clk_i,
   output logic pin_marker_i,
   output logic pin_rx_enable_i,
   output logic [7:0] cell_rx_bus_i,
   output wire pin_a_i,
   output wire pin_b_i,
   output wire pin_clav_i,
   output wire mgmt_serial_data_alt_i,
   input wire logic pin_a_o,
   input wire logic pin_a_oe_n_o,
   input wire logic pin_b_o,
   input wire logic pin_b_oe_n_o,
   input wire logic pin_clav_o,
   input wire logic pin_clav_oe_n_o,
   input wire logic mgmt_serial_data_alt_o,
   input wire logic mgmt_serial_data_alt_oe_n_o
);
   logic lvl = 1'b0;
   initial cell_rx_clk_i = 1'b0;
   initial pin_marker_i = 1'b1;
   initial pin_rx_enable_i = 1'b0;
   initial cell_rx_bus_i = 8'h5A;
   // Wire levels: pull-down on A, pull-up on B and alt data
   assign pin_a_i = pin_a_oe_n_o ? 1'b0 : pin_a_o;
   assign pin_b_i = pin_b_oe_n_o ? 1'b1 : pin_b_o;
   assign pin_clav_i = pin_clav_oe_n_o ? lvl : pin_clav_o;
   assign mgmt_serial_data_alt_i = mgmt_serial_data_alt_oe_n_o ? 1'b1 : mgmt_serial_data_alt_o;
   // Link clock only runs while tick is called, so it stays low between calls
   task tick(input int n);
      repeat (n)
      begin
         #62.5 cell_rx_clk_i = 1'b1;
         #62.5 cell_rx_clk_i = 1'b0;
      end
   endtask : tick
   // Static MAC-side levels on status, marker and enable pins
   task set_mac(input logic v);
      lvl = v;
      pin_marker_i = v;
      pin_rx_enable_i = v;
   endtask : set_mac
   // Enable held over two edges; bus flips once released
   task send(input logic [7:0] d, input logic m);
      pin_rx_enable_i = 1'b1;
      cell_rx_bus_i = d;
      pin_marker_i = m;
      tick(2);
      pin_rx_enable_i = 1'b0;
      cell_rx_bus_i = ~d;
      pin_marker_i = ~m;
      tick(2);
   endtask : send
endmodule : link_partner

/* File: verif/tb_top.sv */
// Self-checking bench for the pin-sharing block
`timescale 1ns/1ps
`include "pin_share_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
   import pin_share_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, cell_port_enable_i = 1'b0;
   logic [1:0] mac_if_select_pins_i = 2'h0, rsp;
   logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0, rd;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   wire cell_rx_clk_i, pin_a_i, pin_b_i, pin_clav_i, mgmt_serial_data_alt_i, pin_marker_i;
   wire pin_rx_enable_i, pin_a_o, pin_a_oe_n_o, pin_b_o, pin_b_oe_n_o, pin_clav_o;
   wire mgmt_serial_clk_alt_o, mgmt_serial_clk_alt_oe_n_o, mgmt_serial_data_alt_o;
   wire mgmt_serial_data_alt_oe_n_o, pin_clav_oe_n_o, mac_carrier_sense_o, reduced_crs_valid_o;
   wire mac_rx_error_o, reduced_rx_error_o, mac_rx_valid_o, tx_cell_addr_bit4_o;
   wire tx_cell_addr_bit3_o, cell_port_enable_o, s_axi_awready_o, s_axi_wready_o;
   wire s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, mac_rx_clk_o;
   wire [7:0] cell_rx_bus_i;
   wire [31:0] s_axi_rdata_o;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   mac_mode_e mac_mode_o;
   int err_count = 0, checked = 0, cyc = 0, gated = 0;
   // Rows: enable, select, output enables, MAC levels, address bits
   logic [14:0] r;
   logic [14:0] rows [5] = '{15'b0_00_00111_10101_00, 15'b0_01_00111_01010_00,
      15'b0_10_00111_10101_00, 15'b0_11_11001_00000_00, 15'b1_00_11110_00000_01};
   always #2.5 clk_i = ~clk_i;
   always @(posedge mac_rx_clk_o) gated++;
   cell_port_mac_pin_sharing dut_u (.clk_i, .rst_n_i, .cell_rx_clk_i, .cell_port_enable_i,
      .mac_if_select_pins_i, .pin_a_i, .pin_a_o, .pin_a_oe_n_o, .pin_b_i, .pin_b_o,
      .pin_b_oe_n_o, .mgmt_serial_clk_alt_o, .mgmt_serial_clk_alt_oe_n_o,
      .mgmt_serial_data_alt_i, .mgmt_serial_data_alt_o, .mgmt_serial_data_alt_oe_n_o,
      .pin_clav_i, .pin_clav_o, .pin_clav_oe_n_o, .pin_marker_i, .pin_rx_enable_i,
      .cell_rx_bus_i, .mac_rx_clk_o, .mac_carrier_sense_o, .reduced_crs_valid_o,
      .mac_rx_error_o, .reduced_rx_error_o, .mac_rx_valid_o, .tx_cell_addr_bit4_o,
      .tx_cell_addr_bit3_o, .cell_port_enable_o, .mac_mode_o, .s_axi_awaddr_i,
      .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hF),
      .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
      .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
      .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);
   link_partner pm_u (.cell_rx_clk_i, .pin_marker_i, .pin_rx_enable_i, .cell_rx_bus_i,
      .pin_a_i, .pin_b_i, .pin_clav_i, .mgmt_serial_data_alt_i, .pin_a_o, .pin_a_oe_n_o,
      .pin_b_o, .pin_b_oe_n_o, .pin_clav_o, .pin_clav_oe_n_o, .mgmt_serial_data_alt_o,
      .mgmt_serial_data_alt_oe_n_o);
   // Verdict and end of run
   task final_report;
      $display("errors %0d of %0d checks", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // Hang guard
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         final_report;
      end
   end
   // Ready moves on rising edges; sample it at the negedge
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, bv;
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      bv = 1'b0;
      while (!bv)
      begin
         @(negedge clk_i);
         ta = s_axi_awready_o & s_axi_awvalid_i;
         tw = s_axi_wready_o & s_axi_wvalid_i;
         bv = s_axi_bvalid_o;
         rsp = s_axi_bresp_o;
         @(posedge clk_i);
         if (ta) s_axi_awvalid_i <= 1'b0;
         if (tw) s_axi_wvalid_i <= 1'b0;
      end
      s_axi_bready_i <= 1'b0;
   endtask : wr
   task rdr(input logic [7:0] a);
      logic ta, rv;
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      rv = 1'b0;
      while (!rv)
      begin
         @(negedge clk_i);
         ta = s_axi_arready_o & s_axi_arvalid_i;
         rv = s_axi_rvalid_o;
         rd = s_axi_rdata_o;
         rsp = s_axi_rresp_o;
         @(posedge clk_i);
         if (ta) s_axi_arvalid_i <= 1'b0;
      end
      s_axi_rready_i <= 1'b0;
   endtask : rdr
   // Straps change only while reset is held
   task rst(input logic en, input logic [1:0] sel);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      cell_port_enable_i <= en;
      mac_if_select_pins_i <= sel;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask : rst
   initial
   begin
      for (int i = 0; i < 5; i++)
      begin
         r = rows[i];
         rst(r[14], r[13:12]);
         pm_u.tick(3);
         pm_u.set_mac(1'b1);
         wr(`PS_REG_MGMT, 32'h7);
         repeat (4) @(posedge clk_i);
         `CHK(cell_port_enable_o, r[14])
         if (!r[14]) `CHK(mac_mode_o, mac_mode_e'(r[13:12]))
         `CHK({pin_a_oe_n_o, pin_b_oe_n_o, mgmt_serial_clk_alt_oe_n_o,
            mgmt_serial_data_alt_oe_n_o, pin_clav_oe_n_o}, r[11:7])
         `CHK({mac_carrier_sense_o, reduced_crs_valid_o, mac_rx_error_o, reduced_rx_error_o,
            mac_rx_valid_o}, r[6:2])
         `CHK({tx_cell_addr_bit4_o, tx_cell_addr_bit3_o}, r[1:0])
         rdr(`PS_REG_STATUS);
         `CHK(rd[3:0], {r[13:12], r[14], 1'b1})
         pm_u.set_mac(1'b0);
      end
      `CHK(gated, 4)
      // Cell mode: byte capture, clear on read, status pin, bad addresses
      pm_u.send(8'hA5, 1'b1);
      repeat (10) @(posedge clk_i);
      rdr(`PS_REG_RXBYTE);
      `CHK(rd[9:0], 10'h3A5)
      rdr(`PS_REG_RXBYTE);
      `CHK(rd[9:0], 10'h1A5)
      wr(`PS_REG_CELL, 32'h1);
      pm_u.tick(4);
      `CHK({pin_clav_oe_n_o, pin_clav_o}, 2'b01)
      rdr(8'h10);
      `CHK(rsp, `PS_RESP_SLVERR)
      wr(8'h14, 32'h0);
      `CHK(rsp, `PS_RESP_SLVERR)
      cell_port_enable_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK(cell_port_enable_o, 1'b1)
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK({cell_port_enable_o, pin_clav_oe_n_o, mac_mode_o}, {2'b01, MODE_MII})
      final_report;
   end
endmodule : tb_top
